// >>> core/tspc_params.svh
`ifndef TSPC_PARAMS_SVH
`define TSPC_PARAMS_SVH

// register offsets (word index on the register port)
`define TSPC_OFF_CORE_CONTROL    4'h0
`define TSPC_OFF_STATUS_WORD     4'h1
`define TSPC_OFF_TRAP_CONTROL    4'h2
`define TSPC_OFF_IRQ_STATUS      4'h3
`define TSPC_OFF_IRQ_MASK        4'h4

// core_control fields
`define TSPC_POS_PRIO_TOP        3

// cpu_status_word fields
`define TSPC_POS_PRIO_LOW_LSB    5
`define TSPC_POS_PRIO_LOW_MSB    7

// interrupt_trap_control_one fields
`define TSPC_POS_NEST_DIS        15
`define TSPC_POS_A_OVF_CAUSE     14
`define TSPC_POS_B_OVF_CAUSE     13
`define TSPC_POS_A_CAT_CAUSE     12
`define TSPC_POS_B_CAT_CAUSE     11
`define TSPC_POS_A_OVF_EN        10
`define TSPC_POS_B_OVF_EN        9
`define TSPC_POS_CAT_EN          8
`define TSPC_POS_SHIFT_CAUSE     7
`define TSPC_POS_DIV0_CAUSE      6
`define TSPC_POS_UNUSED          5
`define TSPC_POS_ARITH_FLAG      4
`define TSPC_POS_ACCESS_FLAG     3

// irq status / mask fields
`define TSPC_POS_IRQ_ARITH       0
`define TSPC_POS_IRQ_ACCESS      1

// reset values
`define TSPC_RST_WORD            16'h0000
`define TSPC_RST_PRIO_LOW        3'h0
`define TSPC_RST_IRQ_MASK        2'h0

// level at which user interrupts are already shut out
`define TSPC_PRIO_LOW_MAX        3'h7

`endif

// >>> core/tspc_pkg.sv
package tspc_pkg;

   typedef logic [15:0] tspc_word_t;
   typedef logic [3:0]  tspc_prio_t;

   // order of the sticky cause flags inside the trap block
   typedef enum logic [2:0] {
      TSPC_F_A_OVF   = 3'h0,
      TSPC_F_B_OVF   = 3'h1,
      TSPC_F_A_CAT   = 3'h2,
      TSPC_F_B_CAT   = 3'h3,
      TSPC_F_SHIFT   = 3'h4,
      TSPC_F_DIV0    = 3'h5,
      TSPC_F_ARITH   = 3'h6,
      TSPC_F_ACCESS  = 3'h7
   } tspc_flag_t;

endpackage

// >>> core/tspc_irq.sv
`timescale 1ns/100ps
`default_nettype none

module tspc_irq
   import tspc_pkg::*;
#(
   parameter int N_EVENTS = 2
)
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   // event pulses
   input  wire logic [N_EVENTS-1:0] event_pulse,
   // software access
   input  wire logic                status_wr,
   input  wire logic                mask_wr,
   input  wire logic [N_EVENTS-1:0] wr_bits,
   // state
   output logic      [N_EVENTS-1:0] status,
   output logic      [N_EVENTS-1:0] mask,
   output logic                     irq
);

   if (N_EVENTS < 1 || N_EVENTS > 16)
   begin : g_check
      $error("tspc_irq: N_EVENTS must lie in 1..16");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [N_EVENTS-1:0] status_q;
   logic [N_EVENTS-1:0] status_d;
   logic [N_EVENTS-1:0] mask_q;
   logic [N_EVENTS-1:0] mask_d;
   logic                irq_q;

   // write one to clear; an event in the same cycle wins over the clear
   for (genvar i = 0; i < N_EVENTS; i++)
   begin : g_flag
      assign status_d[i] = event_pulse[i] | (status_q[i] & ~(status_wr & wr_bits[i]));
   end

   assign mask_d = mask_wr ? wr_bits : mask_q;

   // irq follows the next state so it rises with the status bit
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         status_q <= '0;
         mask_q   <= '0;
         irq_q    <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         mask_q   <= mask_d;
         irq_q    <= |(status_d & mask_d);
      end
   end

   assign status = status_q;
   assign mask   = mask_q;
   assign irq    = irq_q;

endmodule

`default_nettype wire

// >>> core/tspc_top.sv
// Notes on behaviour
// - top priority bit reads 1 when cpu level exceeds 7, else 0.
// - cpu level is the top bit placed above status word bits 7 to 5.
// - nesting disable bit 15: one stops nesting, zero lets interrupts nest.
// - accumulator A or B overflow trap sets cause bit 14 or 13.
// - catastrophic overflow trap of A or B sets cause bit 12 or 11.
// - overflow trap of A needs enable bit 10, of B enable bit 9.
// - catastrophic overflow traps only while enable bit 8 is one.
// - invalid accumulator shift math trap sets cause bit 7.
// - divide by zero math trap sets cause bit 6.
// - any math trap sets arithmetic trap flag bit 4.
// - address error trap sets flag bit 3.
// - trap control bit 5 reads zero and ignores writes.
// - low priority bits are read-only while nesting is disabled.
// - all user interrupts are blocked while the top priority bit is one.
// - software can never set the top priority bit.
//
// Decided for this implementation: the strobed register port and the address map.

`timescale 1ns/100ps
`default_nettype none
`include "tspc_params.svh"

module tspc_top
   import tspc_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   // priority load from the interrupt and trap sequencer
   input  wire logic              priority_load,
   input  wire logic [3:0]        priority_new,
   // trap events from execution and math units
   input  wire logic              acc_a_overflow,
   input  wire logic              acc_b_overflow,
   input  wire logic              acc_a_catastrophic,
   input  wire logic              acc_b_catastrophic,
   input  wire logic              bad_shift,
   input  wire logic              divide_zero,
   input  wire logic              bad_access,
   // trap requests and priority state
   output logic                   arith_trap_req,
   output logic                   bad_access_trap_req,
   output logic      [3:0]        cpu_priority_level,
   output logic                   priority_top_bit,
   output logic                   user_irq_block,
   output logic                   nesting_disable,
   // interrupt
   output logic                   irq
);

   if (ADDR_W < 3 || ADDR_W > 16)
   begin : g_check
      $error("tspc_top: ADDR_W must lie in 3..16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoding

   // one address compare, shared by the write and the read side
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
      addr_hit = (a == ADDR_W'(off));
   endfunction

   // bit position of each sticky cause flag in the trap control word
   function automatic int flag_pos(input int idx);
      case (idx)
         0:       flag_pos = `TSPC_POS_A_OVF_CAUSE;
         1:       flag_pos = `TSPC_POS_B_OVF_CAUSE;
         2:       flag_pos = `TSPC_POS_A_CAT_CAUSE;
         3:       flag_pos = `TSPC_POS_B_CAT_CAUSE;
         4:       flag_pos = `TSPC_POS_SHIFT_CAUSE;
         5:       flag_pos = `TSPC_POS_DIV0_CAUSE;
         6:       flag_pos = `TSPC_POS_ARITH_FLAG;
         default: flag_pos = `TSPC_POS_ACCESS_FLAG;
      endcase
   endfunction

   wire logic hit_core   = addr_hit(reg_addr, `TSPC_OFF_CORE_CONTROL);
   wire logic hit_status = addr_hit(reg_addr, `TSPC_OFF_STATUS_WORD);
   wire logic hit_trap   = addr_hit(reg_addr, `TSPC_OFF_TRAP_CONTROL);
   wire logic hit_istat  = addr_hit(reg_addr, `TSPC_OFF_IRQ_STATUS);
   wire logic hit_imask  = addr_hit(reg_addr, `TSPC_OFF_IRQ_MASK);

   wire logic wr_core   = reg_wr & hit_core;
   wire logic wr_status = reg_wr & hit_status;
   wire logic wr_trap   = reg_wr & hit_trap;
   wire logic wr_istat  = reg_wr & hit_istat;
   wire logic wr_imask  = reg_wr & hit_imask;

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic       prio_top_q;
   logic       prio_top_d;
   logic [2:0] prio_low_q;
   logic [2:0] prio_low_d;
   logic       nest_dis_q;
   logic       nest_dis_d;
   logic       en_a_ovf_q;
   logic       en_b_ovf_q;
   logic       en_cat_q;
   logic       en_a_ovf_d;
   logic       en_b_ovf_d;
   logic       en_cat_d;
   logic [7:0] flag_q;
   logic [7:0] flag_d;
   logic [7:0] flag_set;
   logic       arith_req_q;
   logic       access_req_q;
   logic [3:0] level_q;
   logic       block_q;
   logic [15:0] rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // trap qualification

   // overflow events only count while their enable is set
   wire logic trap_a_ovf = acc_a_overflow & en_a_ovf_q;
   wire logic trap_b_ovf = acc_b_overflow & en_b_ovf_q;
   wire logic trap_a_cat = acc_a_catastrophic & en_cat_q;
   wire logic trap_b_cat = acc_b_catastrophic & en_cat_q;

   // every qualified accumulator, shift or divide event is a math trap
   wire logic trap_arith = trap_a_ovf | trap_b_ovf | trap_a_cat | trap_b_cat
                         | bad_shift | divide_zero;

   assign flag_set[TSPC_F_A_OVF]  = trap_a_ovf;
   assign flag_set[TSPC_F_B_OVF]  = trap_b_ovf;
   assign flag_set[TSPC_F_A_CAT]  = trap_a_cat;
   assign flag_set[TSPC_F_B_CAT]  = trap_b_cat;
   assign flag_set[TSPC_F_SHIFT]  = bad_shift;
   assign flag_set[TSPC_F_DIV0]   = divide_zero;
   assign flag_set[TSPC_F_ARITH]  = trap_arith;
   assign flag_set[TSPC_F_ACCESS] = bad_access;

   // sticky: a set in the same cycle as a software write of zero wins
   for (genvar i = 0; i < 8; i++)
   begin : g_flag
      assign flag_d[i] = flag_set[i] | (wr_trap ? reg_wdata[flag_pos(i)] : flag_q[i]);
   end

   // enables and nesting control are plain read/write bits
   assign nest_dis_d = wr_trap ? reg_wdata[`TSPC_POS_NEST_DIS] : nest_dis_q;
   assign en_a_ovf_d = wr_trap ? reg_wdata[`TSPC_POS_A_OVF_EN] : en_a_ovf_q;
   assign en_b_ovf_d = wr_trap ? reg_wdata[`TSPC_POS_B_OVF_EN] : en_b_ovf_q;
   assign en_cat_d   = wr_trap ? reg_wdata[`TSPC_POS_CAT_EN] : en_cat_q;

   ////////////////////////////////////////////////////////////////////////////
   // priority level

   // software may only clear the top bit; the sequencer load has priority,
   // so a trap entry in the same cycle is never undone by a write
   wire logic top_sw_clr = wr_core & ~reg_wdata[`TSPC_POS_PRIO_TOP];

   assign prio_top_d = priority_load ? priority_new[3]
                     : (top_sw_clr ? 1'b0 : prio_top_q);

   // low bits freeze against software while nesting is disabled
   wire logic low_sw_wr = wr_status & ~nest_dis_q;

   assign prio_low_d = priority_load ? priority_new[2:0]
                     : (low_sw_wr ? reg_wdata[`TSPC_POS_PRIO_LOW_MSB:`TSPC_POS_PRIO_LOW_LSB]
                                  : prio_low_q);

   // level above 7 exactly when the top bit is set
   wire logic [3:0] level_d = {prio_top_d, prio_low_d};

   // top bit shuts out all user interrupts; level 7 does so as well
   wire logic block_d = prio_top_d | (prio_low_d == `TSPC_PRIO_LOW_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // read path

   wire logic [15:0] core_word = 16'(prio_top_q) << `TSPC_POS_PRIO_TOP;

   wire logic [15:0] status_word = 16'(prio_low_q) << `TSPC_POS_PRIO_LOW_LSB;

   logic [15:0] trap_word;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;

   // bit 5 and bits 2..0 are left at zero
   always_comb
   begin
      trap_word = `TSPC_RST_WORD;
      trap_word[`TSPC_POS_NEST_DIS] = nest_dis_q;
      trap_word[`TSPC_POS_A_OVF_EN] = en_a_ovf_q;
      trap_word[`TSPC_POS_B_OVF_EN] = en_b_ovf_q;
      trap_word[`TSPC_POS_CAT_EN]   = en_cat_q;
      for (int i = 0; i < 8; i++)
      begin
         trap_word[flag_pos(i)] = flag_q[i];
      end
   end

   // unmapped addresses read as zero
   wire logic [15:0] rd_mux = hit_core   ? core_word
                            : hit_status ? status_word
                            : hit_trap   ? trap_word
                            : hit_istat  ? 16'(irq_status)
                            : hit_imask  ? 16'(irq_mask)
                            : `TSPC_RST_WORD;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // reset clears all flags and enables
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         flag_q     <= '0;
         nest_dis_q <= 1'b0;
         en_a_ovf_q <= 1'b0;
         en_b_ovf_q <= 1'b0;
         en_cat_q   <= 1'b0;
      end
      else
      begin
         flag_q     <= flag_d;
         nest_dis_q <= nest_dis_d;
         en_a_ovf_q <= en_a_ovf_d;
         en_b_ovf_q <= en_b_ovf_d;
         en_cat_q   <= en_cat_d;
      end
   end

   // priority state and its registered views
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         prio_top_q <= 1'b0;
         prio_low_q <= `TSPC_RST_PRIO_LOW;
         level_q    <= '0;
         block_q    <= 1'b0;
      end
      else
      begin
         prio_top_q <= prio_top_d;
         prio_low_q <= prio_low_d;
         level_q    <= level_d;
         block_q    <= block_d;
      end
   end

   // trap requests copy the events one cycle later and stay high as long as the event does
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         arith_req_q  <= 1'b0;
         access_req_q <= 1'b0;
      end
      else
      begin
         arith_req_q  <= trap_arith;
         access_req_q <= bad_access;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         rdata_q <= `TSPC_RST_WORD;
      end
      else
      begin
         rdata_q <= reg_rd ? rd_mux : `TSPC_RST_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt

   wire logic [1:0] irq_events = {bad_access, trap_arith};

   tspc_irq #(
      .N_EVENTS (2)
   ) u_irq (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .event_pulse (irq_events),
      .status_wr   (wr_istat),
      .mask_wr     (wr_imask),
      .wr_bits     (reg_wdata[1:0]),
      .status      (irq_status),
      .mask        (irq_mask),
      .irq         (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata           = rdata_q;
   assign arith_trap_req      = arith_req_q;
   assign bad_access_trap_req = access_req_q;
   assign cpu_priority_level  = level_q;
   assign priority_top_bit    = prio_top_q;
   assign user_irq_block      = block_q;
   assign nesting_disable     = nest_dis_q;

endmodule

`default_nettype wire

// >>> dv/tspc_exec_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tspc_exec_model
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // commands from the bench
   input  wire logic [6:0] ev_req,
   input  wire logic       ld_req,
   input  wire logic [3:0] ld_val,
   // a_ovf b_ovf a_cat b_cat shift div0 access, then level load
   output logic      [6:0] ev_q,
   output logic            ld_q,
   output logic      [3:0] lvl_q
);
   // one pulse per command; level lines toggle between loads so stale data never helps
   always_ff @(posedge core_clk)
   begin
      ev_q  <= reset_n ? ev_req : 7'h00;
      ld_q  <= reset_n & ld_req;
      lvl_q <= !reset_n ? 4'h0 : (ld_req ? ld_val : ~lvl_q);
   end
endmodule
`default_nettype wire

// >>> dv/tspc_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "tspc_params.svh"
////////////////////////////////////////////////////////////
module tspc_checker
#(
   parameter int ADDR_W = 4
)
(
   // clock and reset
   input wire logic              core_clk,
   input wire logic              reset_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [15:0]       reg_rdata,
   // hardware side
   input wire logic              priority_load,
   input wire logic [3:0]        priority_new,
   input wire logic              bad_shift,
   input wire logic              divide_zero,
   input wire logic              bad_access,
   input wire logic              arith_trap_req,
   input wire logic              bad_access_trap_req,
   input wire logic [3:0]        cpu_priority_level,
   input wire logic              priority_top_bit,
   input wire logic              user_irq_block,
   input wire logic              nesting_disable
);
   localparam logic [ADDR_W-1:0] OFF_CORE = ADDR_W'(`TSPC_OFF_CORE_CONTROL);
   localparam logic [ADDR_W-1:0] OFF_STAT = ADDR_W'(`TSPC_OFF_STATUS_WORD);
   localparam logic [ADDR_W-1:0] OFF_TRAP = ADDR_W'(`TSPC_OFF_TRAP_CONTROL);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // software writes race the hardware load, so the load cycle is left out
   sequence s_math_ev;
      bad_shift || divide_zero;
   endsequence
   sequence s_trap_wr;
      reg_wr && reg_addr == OFF_TRAP;
   endsequence
   sequence s_sw_wr(logic [ADDR_W-1:0] a);
      reg_wr && reg_addr == a && !priority_load;
   endsequence

   property p_math_req;
      s_math_ev |=> arith_trap_req;
   endproperty
   property p_access_req;
      bad_access |=> bad_access_trap_req;
   endproperty
   property p_nest;
      s_trap_wr |=> nesting_disable == $past(reg_wdata[15]);
   endproperty
   property p_top;
      priority_top_bit == cpu_priority_level[3];
   endproperty
   property p_load;
      priority_load |=> cpu_priority_level == $past(priority_new);
   endproperty
   property p_block;
      priority_top_bit |-> user_irq_block;
   endproperty
   property p_sw_top;
      s_sw_wr(OFF_CORE) |=> !$rose(priority_top_bit);
   endproperty
   property p_low_ro;
      nesting_disable ##0 s_sw_wr(OFF_STAT) |=> $stable(cpu_priority_level[2:0]);
   endproperty
   property p_unused;
      reg_rd && reg_addr == OFF_TRAP |=> !reg_rdata[5];
   endproperty

   a_math_req: assert property (p_math_req)
      else $error("no math trap request after shift or divide event");
   a_access_req: assert property (p_access_req)
      else $error("no access trap request after bad access");
   a_nest: assert property (p_nest)
      else $error("nesting disable does not follow write");
   a_top: assert property (p_top)
      else $error("top bit differs from level bit 3");
   a_load: assert property (p_load)
      else $error("level not loaded");
   a_block: assert property (p_block)
      else $error("user interrupts open with top bit set");
   a_sw_top: assert property (p_sw_top)
      else $error("software raised the top bit");
   a_low_ro: assert property (p_low_ro)
      else $error("low bits changed while nesting disabled");
   a_unused: assert property (p_unused)
      else $error("unused trap bit reads one");
endmodule

bind tspc_top tspc_checker #(.ADDR_W(ADDR_W)) chk_u (
   .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .priority_load(priority_load), .priority_new(priority_new), .bad_shift(bad_shift),
   .divide_zero(divide_zero), .bad_access(bad_access), .arith_trap_req(arith_trap_req),
   .bad_access_trap_req(bad_access_trap_req), .cpu_priority_level(cpu_priority_level),
   .priority_top_bit(priority_top_bit), .user_irq_block(user_irq_block),
   .nesting_disable(nesting_disable));
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tb_top
   import tspc_pkg::*;
;
   logic       core_clk = 1'b0;
   logic       reset_n  = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   tspc_word_t reg_wdata = 16'h0000;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [6:0] ev_req = 7'h00;
   logic       ld_req = 1'b0;
   logic [3:0] ld_val = 4'h0;
   wire  [6:0] ev;
   wire        ld;
   wire  [3:0] lvl;
   tspc_word_t reg_rdata;
   logic       arith_trap_req, bad_access_trap_req, priority_top_bit;
   logic       user_irq_block, nesting_disable, irq;
   logic [3:0] cpu_priority_level;
   int         bad_count = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         cb [7] = '{14, 13, 12, 11, 7, 6, 3};
   tspc_word_t e;

   tspc_exec_model exec_u (.core_clk(core_clk), .reset_n(reset_n), .ev_req(ev_req),
      .ld_req(ld_req), .ld_val(ld_val), .ev_q(ev), .ld_q(ld), .lvl_q(lvl));
   tspc_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .priority_load(ld), .priority_new(lvl), .acc_a_overflow(ev[0]),
      .acc_b_overflow(ev[1]), .acc_a_catastrophic(ev[2]), .acc_b_catastrophic(ev[3]),
      .bad_shift(ev[4]), .divide_zero(ev[5]), .bad_access(ev[6]),
      .arith_trap_req(arith_trap_req), .bad_access_trap_req(bad_access_trap_req),
      .cpu_priority_level(cpu_priority_level), .priority_top_bit(priority_top_bit),
      .user_irq_block(user_irq_block), .nesting_disable(nesting_disable), .irq(irq));

   always #5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input tspc_word_t got, input tspc_word_t exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask

   // every task starts and ends on a rising edge; values are looked at on the falling edge
   task automatic wr(input logic [3:0] a, input tspc_word_t d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [3:0] a, input tspc_word_t exp);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, exp);
      @(posedge core_clk);
   endtask

   task automatic fire(input int i, input logic en);
      ev_req <= 7'h01 << i;
      @(posedge core_clk);
      ev_req <= 7'h00;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(16'(arith_trap_req), 16'(en && i < 6));
      chk(16'(bad_access_trap_req), 16'(i == 6));
      chk(16'(irq), 16'(en && i < 6));
      @(posedge core_clk);
   endtask

   task automatic ld_chk(input logic [3:0] v);
      ld_req <= 1'b1;
      ld_val <= v;
      @(posedge core_clk);
      ld_req <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(16'(cpu_priority_level), 16'(v));
      chk(16'(priority_top_bit), 16'(v > 4'h7));
      chk(16'(user_irq_block), 16'(v[3] | (&v[2:0])));
      @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////
   // hang guard, well above the length of the sequence below
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      // reset contents, index 5 is unmapped
      for (int a = 0; a < 6; a++) rd(4'(a), 16'h0000);
      wr(4'h2, 16'hffff);
      rd(4'h2, 16'hffd8);
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h0000);
      // enables clear: overflow and catastrophic events leave no trace
      for (int i = 0; i < 4; i++) fire(i, 1'b0);
      rd(4'h2, 16'h0000);
      wr(4'h4, 16'h0001);
      wr(4'h2, 16'h0700);
      for (int i = 0; i < 7; i++)
      begin
         e = 16'h0700 | (16'h0001 << cb[i]) | (i < 6 ? 16'h0010 : 16'h0000);
         fire(i, 1'b1);
         rd(4'h3, i < 6 ? 16'h0001 : 16'h0002);
         wr(4'h3, 16'h0003);
         rd(4'h3, 16'h0000);
         rd(4'h2, e);
         chk(16'(irq), 16'h0000);
         wr(4'h2, 16'h0700);
      end
      // priority: software low bits, nesting lock, top bit only from hardware
      wr(4'h1, 16'h00e0);
      rd(4'h1, 16'h00e0);
      chk(16'(cpu_priority_level), 16'h0007);
      wr(4'h2, 16'h8000);
      chk(16'(nesting_disable), 16'h0001);
      wr(4'h1, 16'h0020);
      rd(4'h1, 16'h00e0);
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'h0008);
      rd(4'h0, 16'h0000);
      ld_chk(4'h7);
      ld_chk(4'h8);
      ld_chk(4'h9);
      rd(4'h0, 16'h0008);
      rd(4'h1, 16'h0020);
      wr(4'h0, 16'h0000);
      chk(16'(cpu_priority_level), 16'h0001);
      wrap_up();
   end
endmodule
`default_nettype wire
